// ### verilog/pfm_pkg.sv
// Constants for the port function pin multiplexer.
package pfm_pkg;
  localparam int NPORT = 10;
  localparam int NPIN = 80;
  localparam int AW = 8;
  // Register regions selected by address bits 7:6.
  localparam logic [1:0] REGION_PDR = 2'h0;
  localparam logic [1:0] REGION_DDR = 2'h1;
  localparam logic [1:0] REGION_CTL = 2'h2;
  localparam logic [7:0] OFS_BPC = 8'h80;
  localparam logic [7:0] OFS_OD4 = 8'h84;
  localparam logic [7:0] OFS_PU0 = 8'h88;
  localparam logic [7:0] OFS_PU1 = 8'h8C;
  localparam logic [7:0] OFS_PU6 = 8'h90;
  localparam logic [7:0] OFS_SMC = 8'h94;
  localparam logic [7:0] OFS_DAC = 8'h98;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Bit positions in external_pin_control_reg.
  localparam int BPC_WR = 0;
  localparam int BPC_HLD = 1;
  localparam int BPC_RDY = 2;
  localparam int BPC_CLK = 3;
  // Bit positions in serial_mode_ctrl and dac_ctrl_reg.
  localparam int SMC_TX0_EN = 0;
  localparam int SMC_CLK1_EN = 1;
  localparam int DAC_EN0 = 0;
  localparam int DAC_EN1 = 1;
  // Pin indices: port * 8 + bit.
  localparam int PORT3_BIT1 = 25;
  localparam int PORT3_BIT2 = 26;
  localparam int PORT3_BIT3 = 27;
  localparam int PORT3_BIT4 = 28;
  localparam int PORT3_BIT5 = 29;
  localparam int PORT3_BIT6 = 30;
  localparam int PORT3_BIT7 = 31;
  localparam int PORT4_BIT0 = 32;
  localparam int PORT4_BIT1 = 33;
  localparam int PORT4_BIT5 = 37;
  localparam int P5_BASE = 40;
  localparam int PORT6_BIT3 = 51;
  localparam int PORT6_BIT4 = 52;
  localparam int PORT6_BIT5 = 53;
  localparam int PORT7_BIT3 = 59;
  localparam int PORT7_BIT4 = 60;
  localparam int PORT8_BIT6 = 70;
  localparam int PORT8_BIT7 = 71;
  localparam int P9_BASE = 72;
  localparam int P4_PORT = 4;
  localparam int P0_PORT = 0;
  localparam int P1_PORT = 1;
  localparam int P6_PORT = 6;
endpackage

// ### verilog/pfm_pin_mux.sv
// Port function pin multiplexer with port registers and pin control.
`timescale 1ns/1ps
// How it works
// [RULE1] In external bus mode port3_bit1 drives read_strobe_n.
// [RULE2] port3_bit2 drives low_write_strobe_n when bus mode and write enable set.
// [RULE3] port3_bit3 drives high_write_strobe_n in 16-bit bus mode with write enable.
// [RULE4] hold_pins_enable gives port3_bit4 hold request in, port3_bit5 hold ack.
// [RULE5] ready_pin_enable turns port3_bit6 into the external ready input.
// [RULE6] clock_out_pin_enable puts the machine clock on port3_bit7.
// [RULE7] Port 4 open-drain select makes output pins drive low only.
// [RULE8] Pull-up on ports 0, 1, 6 when selected, never while output.
// [RULE9] port4_bit1 drives serial0_tx when enabled; port4_bit0 feeds serial0_rx.
// [RULE10] port4_bit5 is clock input in external clock mode, else serial1_clk out.
// [RULE11] port7_bit3 and port7_bit4 become D/A outputs when enabled.
// [RULE12] Port 5 pins are analog inputs while the converter runs.
// [RULE13] port6_bit3 and port6_bit4 carry pulse generator outputs when enabled.
// [RULE14] port6_bit5 carries clock_monitor_out while the monitor runs.
// [RULE15] Port 9 pins 0-2 feed timer event inputs, undriven in input mode.
// [RULE16] Port 9 pins 3-5 carry timer outputs when enabled, 4-5 also compare.
// [RULE17] port8_bit6 and port8_bit7 inputs stay live in standby.
// [RULE18] Port 9 pins 0-3 also feed the capture trigger inputs.
// [RULE19] Unclaimed pins follow port data and direction; peripherals override data.
// [RULE20] Each pin input reaches port reads and peripherals together.
module pfm_pin_mux
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Register port.
  input wire logic [pfm_pkg::AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Pins.
  input wire logic [pfm_pkg::NPIN-1:0] pin_in,
  output logic [pfm_pkg::NPIN-1:0] pin_out,
  output logic [pfm_pkg::NPIN-1:0] pin_oe_n,
  output logic [pfm_pkg::NPIN-1:0] pin_pullup,
  output logic [1:0] dac_pin_select,
  // Operating state from the core.
  input wire logic ext_bus_mode,
  input wire logic ext_bus16_mode,
  input wire logic standby,
  // Peripheral outputs.
  input wire logic read_strobe_n,
  input wire logic low_write_strobe_n,
  input wire logic high_write_strobe_n,
  input wire logic hold_ack_n,
  input wire logic machine_clk_out,
  input wire logic serial0_tx,
  input wire logic serial1_clk_out,
  input wire logic serial1_ext_clk_mode,
  input wire logic adc_active,
  input wire logic pulse_gen_enable,
  input wire logic [1:0] pulse_gen_out,
  input wire logic clock_monitor_enable,
  input wire logic clock_monitor_out,
  input wire logic [2:0] timer_in_mode,
  input wire logic [2:0] timer_out_enable,
  input wire logic [2:0] timer_out,
  input wire logic [1:0] compare_out_enable,
  input wire logic [1:0] compare_event_out,
  // Peripheral inputs.
  output logic hold_request_in,
  output logic ext_ready_in,
  output logic serial0_rx,
  output logic serial1_clk_in,
  output logic [2:0] timer_event_in,
  output logic [3:0] capture_trig_in,
  output logic [7:0] ext_int_request_in
);

  localparam int NP = pfm_pkg::NPORT;
  localparam int NI = pfm_pkg::NPIN;

  logic [7:0] pdr_r [NP];
  logic [7:0] ddr_r [NP];
  logic [7:0] bpc_r;
  logic [7:0] od4_r;
  logic [7:0] pu0_r;
  logic [7:0] pu1_r;
  logic [7:0] pu6_r;
  logic [7:0] smc_r;
  logic [7:0] dac_r;
  logic [NI-1:0] sync1_r;
  logic [NI-1:0] sync2_r;
  logic [NI-1:0] in_r;
  logic [NI-1:0] fn_en;
  logic [NI-1:0] fn_val;
  logic [NI-1:0] fn_in;
  logic [NI-1:0] pu_sel;
  logic [NI-1:0] drive;
  logic [NI-1:0] level;
  logic [NI-1:0] oe_n_nxt;
  logic [NI-1:0] pu_nxt;
  logic [31:0] rdata_nxt;
  logic [1:0] region;
  logic [3:0] pidx;
  logic pidx_ok;

  assign region = reg_addr[7:6];
  assign pidx = reg_addr[5:2];
  assign pidx_ok = (int'(pidx) < NP);

  // Port data and direction registers.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      for (int p = 0; p < NP; p++)
      begin
        pdr_r[p] <= pfm_pkg::RST_BYTE;
        ddr_r[p] <= pfm_pkg::RST_BYTE;
      end
    end
    else if (reg_wr && pidx_ok)
    begin
      if (region == pfm_pkg::REGION_PDR)
        pdr_r[pidx] <= reg_wdata[7:0];
      if (region == pfm_pkg::REGION_DDR)
        ddr_r[pidx] <= reg_wdata[7:0];
    end
  end

  // Function control registers.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      bpc_r <= pfm_pkg::RST_BYTE;
      od4_r <= pfm_pkg::RST_BYTE;
      pu0_r <= pfm_pkg::RST_BYTE;
      pu1_r <= pfm_pkg::RST_BYTE;
      pu6_r <= pfm_pkg::RST_BYTE;
      smc_r <= pfm_pkg::RST_BYTE;
      dac_r <= pfm_pkg::RST_BYTE;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        pfm_pkg::OFS_BPC: bpc_r <= reg_wdata[7:0];
        pfm_pkg::OFS_OD4: od4_r <= reg_wdata[7:0];
        pfm_pkg::OFS_PU0: pu0_r <= reg_wdata[7:0];
        pfm_pkg::OFS_PU1: pu1_r <= reg_wdata[7:0];
        pfm_pkg::OFS_PU6: pu6_r <= reg_wdata[7:0];
        pfm_pkg::OFS_SMC: smc_r <= reg_wdata[7:0];
        pfm_pkg::OFS_DAC: dac_r <= reg_wdata[7:0];
        default: ;
      endcase
    end
  end

  // Read path. Output pins read back their latch, input pins the pin.
  always_comb
  begin
    rdata_nxt = 32'h0;
    if (pidx_ok && region == pfm_pkg::REGION_PDR)
      rdata_nxt[7:0] = (ddr_r[pidx] & pdr_r[pidx])
        | (~ddr_r[pidx] & in_r[pidx*8 +: 8]); // RULE20
    else if (pidx_ok && region == pfm_pkg::REGION_DDR)
      rdata_nxt[7:0] = ddr_r[pidx];
    else
    begin
      unique case (reg_addr)
        pfm_pkg::OFS_BPC: rdata_nxt[7:0] = bpc_r;
        pfm_pkg::OFS_OD4: rdata_nxt[7:0] = od4_r;
        pfm_pkg::OFS_PU0: rdata_nxt[7:0] = pu0_r;
        pfm_pkg::OFS_PU1: rdata_nxt[7:0] = pu1_r;
        pfm_pkg::OFS_PU6: rdata_nxt[7:0] = pu6_r;
        pfm_pkg::OFS_SMC: rdata_nxt[7:0] = smc_r;
        pfm_pkg::OFS_DAC: rdata_nxt[7:0] = dac_r;
        default: rdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      reg_rdata <= 32'h0;
    else if (reg_rd)
      reg_rdata <= rdata_nxt;
    else
      reg_rdata <= 32'h0;
  end

  // Peripheral claims on pins. fn_in holds a pin off the drivers.
  always_comb
  begin
    fn_en = '0;
    fn_val = '0;
    fn_in = '0;
    if (ext_bus_mode)
    begin
      fn_en[pfm_pkg::PORT3_BIT1] = 1'b1; // RULE1
      fn_val[pfm_pkg::PORT3_BIT1] = read_strobe_n;
      fn_en[pfm_pkg::PORT3_BIT2] = bpc_r[pfm_pkg::BPC_WR]; // RULE2
      fn_val[pfm_pkg::PORT3_BIT2] = low_write_strobe_n;
      fn_en[pfm_pkg::PORT3_BIT3] = ext_bus16_mode
        && bpc_r[pfm_pkg::BPC_WR]; // RULE3
      fn_val[pfm_pkg::PORT3_BIT3] = high_write_strobe_n;
      fn_in[pfm_pkg::PORT3_BIT4] = bpc_r[pfm_pkg::BPC_HLD]; // RULE4
      fn_en[pfm_pkg::PORT3_BIT5] = bpc_r[pfm_pkg::BPC_HLD]; // RULE4
      fn_val[pfm_pkg::PORT3_BIT5] = hold_ack_n;
      fn_in[pfm_pkg::PORT3_BIT6] = bpc_r[pfm_pkg::BPC_RDY]; // RULE5
      fn_en[pfm_pkg::PORT3_BIT7] = bpc_r[pfm_pkg::BPC_CLK]; // RULE6
      fn_val[pfm_pkg::PORT3_BIT7] = machine_clk_out;
    end
    fn_en[pfm_pkg::PORT4_BIT1] = smc_r[pfm_pkg::SMC_TX0_EN]; // RULE9
    fn_val[pfm_pkg::PORT4_BIT1] = serial0_tx;
    // External clock mode wins so two clock drivers never fight.
    if (serial1_ext_clk_mode)
      fn_in[pfm_pkg::PORT4_BIT5] = 1'b1; // RULE10
    else
      fn_en[pfm_pkg::PORT4_BIT5] = smc_r[pfm_pkg::SMC_CLK1_EN]; // RULE10
    fn_val[pfm_pkg::PORT4_BIT5] = serial1_clk_out;
    fn_in[pfm_pkg::P5_BASE +: 8] = {8{adc_active}}; // RULE12
    fn_in[pfm_pkg::PORT7_BIT3] = dac_r[pfm_pkg::DAC_EN0]; // RULE11
    fn_in[pfm_pkg::PORT7_BIT4] = dac_r[pfm_pkg::DAC_EN1]; // RULE11
    fn_en[pfm_pkg::PORT6_BIT3] = pulse_gen_enable; // RULE13
    fn_val[pfm_pkg::PORT6_BIT3] = pulse_gen_out[0];
    fn_en[pfm_pkg::PORT6_BIT4] = pulse_gen_enable; // RULE13
    fn_val[pfm_pkg::PORT6_BIT4] = pulse_gen_out[1];
    fn_en[pfm_pkg::PORT6_BIT5] = clock_monitor_enable; // RULE14
    fn_val[pfm_pkg::PORT6_BIT5] = clock_monitor_out;
    fn_in[pfm_pkg::P9_BASE +: 3] = timer_in_mode; // RULE15
    fn_en[pfm_pkg::P9_BASE + 3] = timer_out_enable[0]; // RULE16
    fn_val[pfm_pkg::P9_BASE + 3] = timer_out[0];
    for (int k = 1; k < 3; k++)
    begin
      fn_en[pfm_pkg::P9_BASE + 3 + k] = timer_out_enable[k]
        || compare_out_enable[k-1]; // RULE16
      fn_val[pfm_pkg::P9_BASE + 3 + k] = timer_out_enable[k] ?
        timer_out[k] : compare_event_out[k-1];
    end
  end

  always_comb
  begin
    pu_sel = '0;
    pu_sel[pfm_pkg::P0_PORT*8 +: 8] = pu0_r;
    pu_sel[pfm_pkg::P1_PORT*8 +: 8] = pu1_r;
    pu_sel[pfm_pkg::P6_PORT*8 +: 8] = pu6_r;
  end

  // Per pin drive resolution.
  genvar gi;
  generate
    for (gi = 0; gi < NI; gi++)
    begin : g_pin
      assign drive[gi] = fn_en[gi] ||
        (!fn_in[gi] && ddr_r[gi/8][gi%8]); // RULE19
      assign level[gi] = fn_en[gi] ? fn_val[gi] : pdr_r[gi/8][gi%8]; // RULE19
      if (gi/8 == pfm_pkg::P4_PORT)
      begin : g_od
        // Open drain releases the pin for a high level instead of driving.
        assign oe_n_nxt[gi] = !(drive[gi] &&
          !(od4_r[gi%8] && level[gi])); // RULE7
      end
      else
      begin : g_pp
        assign oe_n_nxt[gi] = !drive[gi];
      end
      assign pu_nxt[gi] = pu_sel[gi] && !drive[gi]; // RULE8
    end
  endgenerate

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pin_out <= '0;
      pin_oe_n <= '1;
      pin_pullup <= '0;
      dac_pin_select <= 2'h0;
    end
    else
    begin
      pin_out <= level;
      pin_oe_n <= oe_n_nxt;
      pin_pullup <= pu_nxt;
      dac_pin_select <= {dac_r[pfm_pkg::DAC_EN1],
        dac_r[pfm_pkg::DAC_EN0]}; // RULE11
    end
  end

  // Pin inputs are asynchronous, so two stages precede any use.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else
    begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
    end
  end

  // Standby gates input paths; the two wake-up interrupt pins stay live.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      in_r <= '0;
    else
    begin
      for (int k = 0; k < NI; k++)
        in_r[k] <= sync2_r[k] && (!standby
          || k == pfm_pkg::PORT8_BIT6 || k == pfm_pkg::PORT8_BIT7); // RULE17
    end
  end

  // Peripheral inputs are registered copies of the gated pin values.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      hold_request_in <= 1'b0;
      ext_ready_in <= 1'b0;
      serial0_rx <= 1'b0;
      serial1_clk_in <= 1'b0;
      timer_event_in <= 3'h0;
      capture_trig_in <= 4'h0;
      ext_int_request_in <= 8'h00;
    end
    else
    begin
      hold_request_in <= in_r[pfm_pkg::PORT3_BIT4]; // RULE4
      ext_ready_in <= in_r[pfm_pkg::PORT3_BIT6]; // RULE5
      serial0_rx <= in_r[pfm_pkg::PORT4_BIT0]; // RULE9
      serial1_clk_in <= in_r[pfm_pkg::PORT4_BIT5]; // RULE10
      timer_event_in <= in_r[pfm_pkg::P9_BASE +: 3]; // RULE15
      capture_trig_in <= in_r[pfm_pkg::P9_BASE +: 4]; // RULE18
      ext_int_request_in <= in_r[pfm_pkg::PORT8_BIT6-6 +: 8]; // RULE20
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_RD_STROBE: assert property (ext_bus_mode |=> // RULE1
    pin_out[pfm_pkg::PORT3_BIT1] == $past(read_strobe_n)
    && !pin_oe_n[pfm_pkg::PORT3_BIT1])
    else $error("read strobe not on its pin");
  AST_WRL: assert property ((ext_bus_mode && bpc_r[pfm_pkg::BPC_WR]) // RULE2
    |=> pin_out[pfm_pkg::PORT3_BIT2] == $past(low_write_strobe_n))
    else $error("low write strobe not on its pin");
  AST_WRH: assert property ((ext_bus_mode && !ext_bus16_mode) // RULE3
    |=> pin_oe_n[pfm_pkg::PORT3_BIT3] == !$past(ddr_r[3][3]))
    else $error("high write strobe claimed outside 16-bit mode");
  AST_HOLD: assert property ((ext_bus_mode && bpc_r[pfm_pkg::BPC_HLD]) // RULE4
    |=> pin_oe_n[pfm_pkg::PORT3_BIT4] && !pin_oe_n[pfm_pkg::PORT3_BIT5])
    else $error("hold pins not switched");
  AST_READY: assert property (ext_bus_mode // RULE5
    && bpc_r[pfm_pkg::BPC_RDY] |=> pin_oe_n[pfm_pkg::PORT3_BIT6])
    else $error("ready pin driven");
  AST_CLKOUT: assert property (ext_bus_mode // RULE6
    && bpc_r[pfm_pkg::BPC_CLK] |=> pin_out[pfm_pkg::PORT3_BIT7]
    == $past(machine_clk_out))
    else $error("clock not on its pin");
  AST_OPEN_DRAIN: assert property ((od4_r[2] && ddr_r[4][2] // RULE7
    && pdr_r[4][2]) |=> pin_oe_n[pfm_pkg::PORT4_BIT0 + 2])
    else $error("open drain pin drove high");
  AST_PULLUP: assert property (ddr_r[0][0] |=> !pin_pullup[0]) // RULE8
    else $error("pull-up on an output pin");
  AST_TX: assert property (smc_r[pfm_pkg::SMC_TX0_EN] |=> // RULE9
    pin_out[pfm_pkg::PORT4_BIT1] == $past(serial0_tx))
    else $error("serial output not on its pin");
  AST_ANALOG: assert property (adc_active |=> // RULE12
    &pin_oe_n[pfm_pkg::P5_BASE +: 8])
    else $error("analog pin driven");
  AST_STANDBY_IRQ: assert property ((standby // RULE17
    && pin_in[pfm_pkg::PORT8_BIT6])[*3] ##1 1'b1 [*2]
    |-> ext_int_request_in[6])
    else $error("wake-up input gated in standby");
  AST_SHARED_IN: assert property (!$past(standby, 2) |-> // RULE18
    capture_trig_in == $past(sync2_r[pfm_pkg::P9_BASE +: 4], 2)
    && timer_event_in == capture_trig_in[2:0])
    else $error("capture inputs do not follow port 9 pins");

  COV_EXT_BUS: cover property (ext_bus_mode && bpc_r == 8'h0F);
  COV_OD_LOW: cover property (od4_r[2] && !pin_oe_n[pfm_pkg::PORT4_BIT0 + 2]);
  COV_STANDBY: cover property (standby && ext_int_request_in[7]);
  COV_READ: cover property (reg_rd ##1 reg_rdata != 32'h0);

endmodule

// ### tb/pfm_board_model.sv
// Board model that resolves every pin from the device and external parts.
`timescale 1ns/1ps
module pfm_board_model
(
  // Clock.
  input wire logic sys_clk,
  // Device pin controls.
  input wire logic [pfm_pkg::NPIN-1:0] pin_out,
  input wire logic [pfm_pkg::NPIN-1:0] pin_oe_n,
  input wire logic [pfm_pkg::NPIN-1:0] pin_pullup,
  // External drivers on the board.
  input wire logic [pfm_pkg::NPIN-1:0] ext_en,
  input wire logic [pfm_pkg::NPIN-1:0] ext_val,
  // Resolved pin levels.
  output logic [pfm_pkg::NPIN-1:0] pin_in
);
  logic [pfm_pkg::NPIN-1:0] last_r = '0;

  // A floating pin flips every cycle, so a stale level never looks like data.
  always_ff @(posedge sys_clk)
  begin
    last_r <= ~pin_in;
  end

  always_comb
  begin
    for (int i = 0; i < pfm_pkg::NPIN; i++)
    begin
      if (!pin_oe_n[i])
        pin_in[i] = pin_out[i];
      else if (ext_en[i])
        pin_in[i] = ext_val[i];
      else if (pin_pullup[i])
        pin_in[i] = 1'b1;
      else
        pin_in[i] = last_r[i];
    end
  end
endmodule

// ### tb/port_function_pin_mux_bench.sv
// Self-checking bench for the port function pin multiplexer.
`timescale 1ns/1ps
module port_function_pin_mux_bench;
  typedef struct packed
  {
    logic [13:0] ctl;
    logic [23:0] cfg;
    logic [6:0] pin;
    logic [1:0] exp;
  } pfm_row_t;

  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [79:0] pin_in, pin_out, pin_oe_n, pin_pullup;
  logic [79:0] ext_en = '0;
  logic [79:0] ext_val = '0;
  logic [13:0] ctl = 14'h0000;
  logic [14:0] lvl = 15'h7FFF;
  logic standby = 1'b0;
  logic [1:0] dac_pin_select;
  logic hold_req, ready_in, rx0, clk1_in;
  logic [2:0] tev;
  logic [3:0] cap;
  logic [7:0] irq;
  int num_errors = 0;
  int n_tests = 0;
  // Fields: ctl, {bus pins, serial, dac}, pin, {out, oe_n}.
  pfm_row_t rows [0:30] = '{
    '{14'h2000, 24'h000000, 7'h19, 2'h2},
    '{14'h0000, 24'h000000, 7'h19, 2'h0},
    '{14'h2000, 24'h010000, 7'h1A, 2'h2},
    '{14'h2000, 24'h000000, 7'h1A, 2'h0},
    '{14'h3000, 24'h010000, 7'h1B, 2'h2},
    '{14'h2000, 24'h010000, 7'h1B, 2'h0},
    '{14'h2000, 24'h020000, 7'h1D, 2'h2},
    '{14'h2000, 24'h020000, 7'h1C, 2'h1},
    '{14'h0000, 24'h020000, 7'h1D, 2'h0},
    '{14'h2000, 24'h040000, 7'h1E, 2'h1},
    '{14'h0000, 24'h040000, 7'h1E, 2'h0},
    '{14'h2000, 24'h080000, 7'h1F, 2'h2},
    '{14'h2000, 24'h000000, 7'h1F, 2'h0},
    '{14'h0000, 24'h000100, 7'h21, 2'h2},
    '{14'h0000, 24'h000000, 7'h21, 2'h0},
    '{14'h0000, 24'h000200, 7'h25, 2'h2},
    '{14'h0800, 24'h000200, 7'h25, 2'h1},
    '{14'h0000, 24'h000001, 7'h3B, 2'h1},
    '{14'h0000, 24'h000002, 7'h3C, 2'h1},
    '{14'h0000, 24'h000001, 7'h3C, 2'h0},
    '{14'h0400, 24'h000000, 7'h2B, 2'h1},
    '{14'h0200, 24'h000000, 7'h33, 2'h2},
    '{14'h0200, 24'h000000, 7'h34, 2'h2},
    '{14'h0000, 24'h000000, 7'h34, 2'h0},
    '{14'h0100, 24'h000000, 7'h35, 2'h2},
    '{14'h0020, 24'h000000, 7'h48, 2'h1},
    '{14'h0008, 24'h000000, 7'h4C, 2'h2},
    '{14'h0001, 24'h000000, 7'h4C, 2'h2},
    '{14'h0004, 24'h000000, 7'h4B, 2'h2},
    '{14'h0002, 24'h000000, 7'h4D, 2'h2},
    '{14'h0000, 24'h000000, 7'h4C, 2'h0}
  };

  always #12.5 sys_clk = ~sys_clk;

  pfm_pin_mux dut
  (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup),
    .dac_pin_select(dac_pin_select), .ext_bus_mode(ctl[13]),
    .ext_bus16_mode(ctl[12]), .standby(standby),
    .read_strobe_n(lvl[0]), .low_write_strobe_n(lvl[1]),
    .high_write_strobe_n(lvl[2]), .hold_ack_n(lvl[3]),
    .machine_clk_out(lvl[4]), .serial0_tx(lvl[5]),
    .serial1_clk_out(lvl[6]), .serial1_ext_clk_mode(ctl[11]),
    .adc_active(ctl[10]), .pulse_gen_enable(ctl[9]),
    .pulse_gen_out(lvl[8:7]), .clock_monitor_enable(ctl[8]),
    .clock_monitor_out(lvl[9]), .timer_in_mode(ctl[7:5]),
    .timer_out_enable(ctl[4:2]), .timer_out(lvl[12:10]),
    .compare_out_enable(ctl[1:0]), .compare_event_out(lvl[14:13]),
    .hold_request_in(hold_req), .ext_ready_in(ready_in),
    .serial0_rx(rx0), .serial1_clk_in(clk1_in),
    .timer_event_in(tev), .capture_trig_in(cap),
    .ext_int_request_in(irq)
  );

  pfm_board_model board
  (
    .sys_clk(sys_clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val),
    .pin_in(pin_in)
  );

  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= {24'h000000, d};
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // The whole run needs well under a thousand cycles.
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    num_errors++;
    results();
  end

  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    chk(pin_oe_n, {80{1'b1}});
    chk(pin_pullup, 80'h0);
    rchk(pfm_pkg::OFS_BPC, 32'h00000000);
    wr(pfm_pkg::OFS_BPC, 8'h0F);
    rchk(pfm_pkg::OFS_BPC, 32'h0000000F);
    wr(8'hFC, 8'hAA);
    rchk(8'hFC, 32'h00000000);
    for (int p = 0; p < 10; p++)
      wr(8'h40 + 8'(4 * p), 8'hFF);
    for (int i = 0; i < 31; i++)
    begin
      @(posedge sys_clk);
      ctl <= rows[i].ctl;
      wr(pfm_pkg::OFS_BPC, rows[i].cfg[23:16]);
      wr(pfm_pkg::OFS_SMC, rows[i].cfg[15:8]);
      wr(pfm_pkg::OFS_DAC, rows[i].cfg[7:0]);
      settle(3);
      chk(pin_oe_n[rows[i].pin], rows[i].exp[0]);
      if (!rows[i].exp[0])
        chk(pin_out[rows[i].pin], rows[i].exp[1]);
    end
    wr(pfm_pkg::OFS_DAC, 8'h03);
    settle(2);
    chk(dac_pin_select, 2'h3);
    wr(8'h40, 8'h00);
    wr(pfm_pkg::OFS_PU0, 8'hFF);
    settle(2);
    chk(pin_pullup[7:0], 8'hFF);
    wr(8'h40, 8'h0F);
    wr(pfm_pkg::OFS_PU6, 8'hFF);
    settle(2);
    chk(pin_pullup[7:0], 8'hF0);
    chk(pin_pullup[55:48], 8'h00);
    wr(8'h10, 8'h04);
    wr(pfm_pkg::OFS_OD4, 8'h04);
    settle(2);
    chk(pin_oe_n[34], 1'b1);
    wr(8'h10, 8'h00);
    settle(2);
    chk({pin_out[34], pin_oe_n[34]}, 2'h0);
    // Inputs: hold and ready claimed, external shift clock, ports 4, 8, 9 in.
    @(posedge sys_clk);
    ctl <= 14'h2800;
    lvl <= 15'h0000;
    ext_en <= {8'hFF, 8'hFF, 24'h0, 8'h21, 8'h50, 24'h0};
    ext_val <= {8'h0D, 8'hC3, 24'h0, 8'h21, 8'h50, 24'h0};
    wr(pfm_pkg::OFS_BPC, 8'h06);
    wr(8'h0C, 8'hFF);
    wr(8'h50, 8'h00);
    wr(8'h60, 8'h00);
    wr(8'h64, 8'h00);
    settle(6);
    chk(pin_out[29], 1'b0);
    chk(pin_out[25], 1'b0);
    chk(hold_req, 1'b1);
    chk(ready_in, 1'b1);
    chk(rx0, 1'b1);
    chk(clk1_in, 1'b1);
    chk(tev, 3'h5);
    chk(cap, 4'hD);
    chk(irq, 8'hC3);
    rchk(8'h24, 32'h0000000D);
    @(posedge sys_clk);
    standby <= 1'b1;
    settle(6);
    chk(irq, 8'hC0);
    results();
  end
endmodule
